// file: rtl/serial_flash_pin_front_end.sv
// Pin front end of a serial flash slave with receive FIFO
`timescale 1ns/1ns
`include "flash_front_map.svh"

module rx_fifo #(
    parameter int WIDTH = `FIFO_WIDTH,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o = mem[rptr];

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wptr] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            wptr <= push ? wptr + 1'b1 : wptr;
            rptr <= pop ? rptr + 1'b1 : rptr;
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule : rx_fifo

////////////////////////////////////////////////////////////////////////////////

module serial_flash_pin_front_end (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic data_lane_zero_i,
    input wire logic data_lane_one_i,
    input wire logic data_lane_two_i,
    input wire logic data_lane_three_i,
    input wire logic reset_pin_n_i,
    output flash_front_pkg::lane_drive_t lanes_o,
    input wire flash_front_pkg::lane_mode_t lane_mode_i,
    input wire logic drive_i,
    input wire logic pin_role_select_i,
    input wire logic dedicated_reset_variant_i,
    input wire logic reset_pin_disable_i,
    input wire logic status_wr_i,
    input wire flash_front_pkg::status_bits_t status_wr_data_i,
    output flash_front_pkg::status_bits_t status_o,
    output logic status_wr_reject_o,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    output logic rx_overflow_o,
    input wire logic rx_overflow_clr_i,
    output logic standby_o
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage a feeds stage b only
    logic [6:0] sync_a;
    logic [6:0] sync_b;
    logic sck_q;
    logic cs_q;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync_a <= `PIN_SYNC_RESET;
            sync_b <= `PIN_SYNC_RESET;
            sck_q <= 1'b1;
            cs_q <= 1'b0;
        end else begin
            sync_a <= {reset_pin_n_i, cs_n_i, sck_i, data_lane_three_i, data_lane_two_i,
                       data_lane_one_i, data_lane_zero_i};
            sync_b <= sync_a;
            sck_q <= sync_b[4];
            cs_q <= sync_b[5];
        end
    end

    wire [3:0] lane_s = sync_b[3:0];
    wire cs_s = sync_b[5];
    wire rst_pin_s = sync_b[6];
    wire sck_rise = sync_b[4] && !sck_q;
    wire sck_fall = !sync_b[4] && sck_q;
    // Cs_q resets low so a select already low at release never arms
    wire cs_fall = cs_q && !cs_s;

    ////////////////////////////////////////////////////////////////////////////
    // Lane three role and hardware reset
    wire qe = status_o.quad_lane_enable;
    wire pause_role = !qe && (dedicated_reset_variant_i || !pin_role_select_i);
    wire reset_role = !qe && !dedicated_reset_variant_i && pin_role_select_i;
    wire pause_low = pause_role && !lane_s[3];
    wire hw_rst = (reset_role && !lane_s[3])
        || (dedicated_reset_variant_i && !reset_pin_disable_i && !rst_pin_s);

    flash_front_pkg::front_state_t state;
    flash_front_pkg::front_state_t next_state;

    always_comb begin
        next_state = state;
        if (hw_rst) begin
            next_state = flash_front_pkg::ST_HW_RESET;
        end else begin
            case (state)
                flash_front_pkg::ST_WAIT_EDGE: begin
                    if (cs_fall) next_state = flash_front_pkg::ST_ACTIVE;
                end
                flash_front_pkg::ST_HW_RESET: next_state = flash_front_pkg::ST_WAIT_EDGE;
                flash_front_pkg::ST_STANDBY: begin
                    if (!cs_s) next_state = flash_front_pkg::ST_ACTIVE;
                end
                flash_front_pkg::ST_ACTIVE: begin
                    if (cs_s) next_state = flash_front_pkg::ST_STANDBY;
                    else if (pause_low) next_state = flash_front_pkg::ST_PAUSED;
                end
                flash_front_pkg::ST_PAUSED: begin
                    if (cs_s) next_state = flash_front_pkg::ST_STANDBY;
                    else if (!pause_low) next_state = flash_front_pkg::ST_ACTIVE;
                end
                default: next_state = flash_front_pkg::ST_WAIT_EDGE;
            endcase
        end
    end

    // Run only when selected now, so a late deselect never clocks a bit
    wire run = (state == flash_front_pkg::ST_ACTIVE) && !cs_s && !pause_low && !hw_rst;
    wire frame_end = (next_state != flash_front_pkg::ST_ACTIVE)
        && (next_state != flash_front_pkg::ST_PAUSED);

    ////////////////////////////////////////////////////////////////////////////
    // Lane width per mode
    wire quad = (lane_mode_i == flash_front_pkg::LANE_QUAD);
    wire dual = (lane_mode_i == flash_front_pkg::LANE_DUAL);
    wire [3:0] step = quad ? 4'h4 : (dual ? 4'h2 : 4'h1);
    wire [3:0] lane_mask = quad ? 4'hF : (dual ? 4'h3 : 4'h2);

    // Receive: capture on rising edge while the core is not driving
    logic [7:0] rx_shift;
    logic [3:0] rx_cnt;
    wire capture = run && sck_rise && !drive_i;
    wire [7:0] next_rx_shift = quad ? {rx_shift[3:0], lane_s}
        : (dual ? {rx_shift[5:0], lane_s[1:0]} : {rx_shift[6:0], lane_s[0]});
    wire [3:0] next_rx_cnt = rx_cnt + step;
    wire byte_done = capture && (next_rx_cnt == `BYTE_BITS);
    wire fifo_ready;
    wire push = byte_done && fifo_ready;
    // Pins cannot be stalled; a byte meeting a full FIFO is dropped and flagged
    wire drop = byte_done && !fifo_ready;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rx_shift <= 8'h00;
            rx_cnt <= 4'h0;
        end else if (frame_end) begin
            rx_cnt <= 4'h0;
        end else if (capture) begin
            rx_shift <= next_rx_shift;
            rx_cnt <= byte_done ? 4'h0 : next_rx_cnt;
        end
    end

    rx_fifo #(.WIDTH(`FIFO_WIDTH), .DEPTH(`FIFO_DEPTH)) u_rx_fifo (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_valid_i(byte_done),
        .in_ready_o(fifo_ready),
        .in_data_i(next_rx_shift),
        .out_valid_o(rx_valid_o),
        .out_ready_i(rx_ready_i),
        .out_data_o(rx_data_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Transmit: change lanes on falling edge
    logic [7:0] tx_shift;
    logic [3:0] tx_cnt;
    wire shift_out = run && sck_fall && drive_i;
    wire tx_empty = (tx_cnt == 4'h0);
    wire tx_load = shift_out && tx_empty && tx_valid_i;
    wire tx_go = shift_out && (!tx_empty || tx_valid_i);
    wire [7:0] tx_word = tx_empty ? tx_data_i : tx_shift;
    wire [3:0] tx_bits = quad ? tx_word[7:4]
        : (dual ? {2'b11, tx_word[7:6]} : {2'b11, tx_word[7], 1'b1});
    wire [3:0] next_tx_cnt = (tx_empty ? `BYTE_BITS : tx_cnt) - step;
    wire drive_ok = run && drive_i;
    // Outputs off unless selected, armed, unpaused and out of reset
    wire [3:0] next_enable = drive_ok || ((state == flash_front_pkg::ST_ACTIVE)
        && !cs_s && !pause_low && !hw_rst && drive_i) ? lane_mask : 4'h0;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tx_shift <= 8'h00;
            tx_cnt <= 4'h0;
            tx_ready_o <= 1'b0;
            lanes_o <= '0;
        end else begin
            tx_ready_o <= tx_load;
            lanes_o.enable <= next_enable;
            if (frame_end) begin
                tx_cnt <= 4'h0;
            end else if (tx_go) begin
                tx_shift <= tx_word << step;
                tx_cnt <= next_tx_cnt;
                lanes_o.value <= tx_bits;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Status bits and write protection
    wire wp_active = status_o.status_write_disable && !lane_s[2] && !qe;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            status_o <= `STATUS_RESET;
            status_wr_reject_o <= 1'b0;
            rx_overflow_o <= 1'b0;
            standby_o <= 1'b1;
            state <= flash_front_pkg::ST_WAIT_EDGE;
        end else begin
            state <= next_state;
            standby_o <= (next_state != flash_front_pkg::ST_ACTIVE)
                && (next_state != flash_front_pkg::ST_PAUSED);
            status_wr_reject_o <= status_wr_i && wp_active;
            if (status_wr_i && !wp_active) begin
                status_o <= status_wr_data_i;
            end
            // Set wins over clear
            rx_overflow_o <= drop || (rx_overflow_o && !rx_overflow_clr_i);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_DESELECT_HIZ: assert property (cs_s |=> lanes_o.enable == 4'h0)
        else $error("lanes driven while deselected");
    AST_DESELECT_IGNORE: assert property (cs_s |=> $stable(rx_shift) && !push)
        else $error("bit captured while deselected");
    AST_STANDBY: assert property (cs_s ##1 cs_s |=> standby_o)
        else $error("not in standby while deselected");
    AST_ARM_EDGE: assert property ((state == flash_front_pkg::ST_WAIT_EDGE) |-> !capture)
        else $error("capture before first select edge");
    AST_SINGLE_CAPTURE: assert property (capture && !quad && !dual
        |=> rx_shift[0] == $past(lane_s[0]))
        else $error("single lane bit not captured");
    AST_VALUE_ON_FALL: assert property ($changed(lanes_o.value) |-> $past(sck_fall, 1))
        else $error("lane value changed off a falling edge");
    AST_QUAD_ENABLE: assert property (drive_ok && quad |=> lanes_o.enable == 4'hF)
        else $error("quad read not on four lanes");
    AST_WP_REJECT: assert property (status_wr_i && wp_active
        |=> $stable(status_o) && status_wr_reject_o)
        else $error("protected status write accepted");
    AST_SWD_CLEAR: assert property (status_wr_i && !status_o.status_write_disable
        |=> status_o == $past(status_wr_data_i))
        else $error("unprotected status write lost");
    AST_PAUSE_HOLD: assert property (pause_low && !hw_rst |=> $stable(rx_cnt)
        && lanes_o.enable == 4'h0)
        else $error("pause disturbed the sequence or output");
    AST_HW_RESET: assert property (hw_rst |=> lanes_o.enable == 4'h0
        ##1 state != flash_front_pkg::ST_ACTIVE)
        else $error("outputs or state active in hardware reset");

    COV_BYTE_IN: cover property (push);
    COV_QUAD_READ: cover property (tx_go && quad);
    COV_PAUSE_RESUME: cover property (state == flash_front_pkg::ST_PAUSED
        ##1 state == flash_front_pkg::ST_ACTIVE);
    COV_WP_REJECT: cover property (status_wr_reject_o);
endmodule : serial_flash_pin_front_end

// file: rtl/flash_front_map.svh
// Constants of the serial flash pin front end
// Summary of operation
// - Select high: deselected, all lanes high impedance
// - Select high: incoming bits ignored
// - Deselected means standby; select low wakes
// - No command before first select falling edge
// - Single lane: capture lane zero on rise
// - Single lane: drive lane one on fall
// - Dual/quad: lanes bidirectional, rise in, fall out
// - Quad uses lanes two and three as data
// - Guard set, protect pin low: reject status write
// - Guard clear: status writes always allowed
// - Quad enable drops write protect function
// - Lane three: data, pause or reset role
// - Pause suspends, keeps partial sequence, resumes
// - Pause with select low: output high impedance
// - Reset low: reset mode, outputs tristated
// - Separate reset variant: lane three pause only
// - Function bit zero disables separate reset
`ifndef FLASH_FRONT_MAP_SVH
`define FLASH_FRONT_MAP_SVH
`define STATUS_RESET 6'h00
`define PIN_SYNC_RESET 7'h5F
`define BYTE_BITS 4'h8
`define FIFO_WIDTH 8
`define FIFO_DEPTH 16
`endif

// file: rtl/flash_front_pkg.sv
// Types of the serial flash pin front end
package flash_front_pkg;
    typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} lane_mode_t;
    typedef enum logic [2:0] {ST_WAIT_EDGE, ST_STANDBY, ST_ACTIVE, ST_PAUSED, ST_HW_RESET}
        front_state_t;
    typedef struct packed {
        logic status_write_disable;
        logic quad_lane_enable;
        logic block_guard_3;
        logic block_guard_2;
        logic block_guard_1;
        logic block_guard_0;
    } status_bits_t;
    typedef struct packed {
        logic [3:0] value;
        logic [3:0] enable;
    } lane_drive_t;
endpackage : flash_front_pkg

// file: verif/spi_host_model.sv
// Behavioural SPI host driving the flash front end pins
`timescale 1ns/1ns
module spi_host_model (
    input wire logic clk_i,
    input wire flash_front_pkg::lane_drive_t lanes_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic [3:0] lane_o
);
    logic [3:0] hval = 4'hF;
    logic [3:0] hoe = 4'hD;
    logic pat = 1'b0;
    initial sck_o = 1'b0; // Mode 0, clock idles low
    initial cs_n_o = 1'b1;
    always @(posedge clk_i) pat <= ~pat;
    // Released lanes toggle so a stale level never passes for data
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lane_o[i] = hoe[i] ? hval[i] : (lanes_i.enable[i] ? lanes_i.value[i] : pat);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk_i);
    endtask : wait_clk
    task automatic set_cs(input logic level);
        wait_clk(8);
        cs_n_o <= level; // Falling edge always precedes a command
        wait_clk(8);
    endtask : set_cs
    task automatic set_lane(input int idx, input logic v);
        @(posedge clk_i);
        hval[idx] <= v;
    endtask : set_lane
    // Data set while clock low, taken by the device on the rise
    task automatic send(input logic [7:0] data, input int width);
        logic [7:0] sh;
        sh = data;
        for (int i = 0; i < 8 / width; i++) begin
            @(posedge clk_i);
            hoe <= (width == 1) ? 4'hD : 4'hF;
            if (width == 1) hval[0] <= sh[7];
            else if (width == 2) hval[1:0] <= sh[7:6];
            else hval <= sh[7:4];
            sh = sh << width;
            wait_clk(8);
            sck_o <= 1'b1;
            wait_clk(8);
            sck_o <= 1'b0;
        end
        @(posedge clk_i);
        hval <= 4'hF;
        hoe <= 4'hD;
    endtask : send
    // Device lanes released; sampled well after the fall
    task automatic recv(input int n, input int width, inout logic [7:0] sh);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            hoe <= (width == 4) ? 4'h0 : ((width == 2) ? 4'hC : 4'hD);
            wait_clk(7);
            sck_o <= 1'b1;
            wait_clk(8);
            sck_o <= 1'b0;
            wait_clk(8);
            if (width == 4) sh = {sh[3:0], lane_o};
            else if (width == 2) sh = {sh[5:0], lane_o[1:0]};
            else sh = {sh[6:0], lane_o[1]};
        end
        @(posedge clk_i);
        hoe <= 4'hD;
    endtask : recv
endmodule : spi_host_model

// file: verif/serial_flash_pin_front_end_tb_top.sv
// Self-checking bench of the serial flash pin front end
`timescale 1ns/1ns
module serial_flash_pin_front_end_tb_top;
    logic clk;
    logic rst;
    logic sck, cs_n;
    logic [3:0] lane;
    flash_front_pkg::lane_drive_t lanes;
    flash_front_pkg::lane_mode_t mode;
    flash_front_pkg::status_bits_t st, st_wd;
    logic drive, role, ded, dis, st_wr, rej;
    logic [7:0] tx_data, rx_data;
    logic tx_valid, tx_ready, rx_valid, rx_ready, ovf, ovf_clr;
    logic standby, rpin_n;
    int tx_loads = 0;
    int fails = 0;
    int num_checks = 0;
    spi_host_model host (.clk_i(clk), .lanes_i(lanes), .sck_o(sck), .cs_n_o(cs_n),
        .lane_o(lane));
    serial_flash_pin_front_end uut (.clk_i(clk), .rst_i(rst), .sck_i(sck), .cs_n_i(cs_n),
        .data_lane_zero_i(lane[0]), .data_lane_one_i(lane[1]), .data_lane_two_i(lane[2]),
        .data_lane_three_i(lane[3]), .reset_pin_n_i(rpin_n), .lanes_o(lanes),
        .lane_mode_i(mode), .drive_i(drive), .pin_role_select_i(role),
        .dedicated_reset_variant_i(ded), .reset_pin_disable_i(dis), .status_wr_i(st_wr),
        .status_wr_data_i(st_wd), .status_o(st), .status_wr_reject_o(rej),
        .tx_data_i(tx_data), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
        .rx_data_o(rx_data), .rx_valid_o(rx_valid), .rx_ready_i(rx_ready),
        .rx_overflow_o(ovf), .rx_overflow_clr_i(ovf_clr), .standby_o(standby));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Counts read byte loads, since the ready pulse lasts one cycle
    always @(posedge clk) begin
        if (tx_ready === 1'b1) tx_loads <= tx_loads + 1;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic wr_status(input logic [5:0] d, input logic [5:0] es, input logic er);
        @(posedge clk);
        st_wr <= 1'b1;
        st_wd <= d;
        @(posedge clk);
        st_wr <= 1'b0;
        #1;
        check({2'h0, st}, {2'h0, es});
        check({7'h00, rej}, {7'h00, er});
    endtask : wr_status
    task automatic rx_expect(input logic [7:0] exp);
        @(posedge clk);
        #1;
        repeat (200) begin
            if (rx_valid === 1'b1) break;
            @(posedge clk);
            #1;
        end
        check({7'h00, rx_valid}, 8'h01);
        check(rx_data, exp);
        @(posedge clk);
        rx_ready <= 1'b1;
        @(posedge clk);
        rx_ready <= 1'b0;
    endtask : rx_expect
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_select;
        check({7'h00, standby}, 8'h01);
        check({4'h0, lanes.enable}, 8'h00);
        host.send(8'h5A, 1);
        #1;
        check({7'h00, rx_valid}, 8'h00);
        host.set_cs(1'b0);
        #1;
        check({7'h00, standby}, 8'h00);
        host.send(8'hA5, 1);
        rx_expect(8'hA5);
        @(posedge clk);
        mode <= flash_front_pkg::LANE_DUAL;
        host.send(8'hC3, 2);
        rx_expect(8'hC3);
        host.set_cs(1'b1);
        #1;
        check({7'h00, standby}, 8'h01);
        $display("t_select done");
    endtask : t_select
    task automatic t_status;
        wr_status(6'h25, 6'h25, 1'b0);
        host.set_lane(2, 1'b0);
        host.wait_clk(6);
        wr_status(6'h3F, 6'h25, 1'b1);
        host.set_lane(2, 1'b1);
        host.wait_clk(6);
        wr_status(6'h31, 6'h31, 1'b0);
        host.set_lane(2, 1'b0);
        host.wait_clk(6);
        wr_status(6'h10, 6'h10, 1'b0);
        host.set_lane(2, 1'b1);
        $display("t_status done");
    endtask : t_status
    task automatic t_quad_fifo;
        @(posedge clk);
        mode <= flash_front_pkg::LANE_QUAD;
        host.set_cs(1'b0);
        for (int i = 0; i < 17; i++) host.send({i[3:0], ~i[3:0]}, 4);
        #1;
        check({7'h00, ovf}, 8'h01);
        for (int i = 0; i < 16; i++) rx_expect({i[3:0], ~i[3:0]});
        #1;
        check({7'h00, rx_valid}, 8'h00);
        @(posedge clk);
        ovf_clr <= 1'b1;
        @(posedge clk);
        ovf_clr <= 1'b0;
        #1;
        check({7'h00, ovf}, 8'h00);
        host.set_cs(1'b1);
        $display("t_quad_fifo done");
    endtask : t_quad_fifo
    task automatic t_read;
        logic [7:0] sh;
        int base;
        sh = 8'h00;
        base = tx_loads;
        wr_status(6'h00, 6'h00, 1'b0);
        @(posedge clk);
        mode <= flash_front_pkg::LANE_SINGLE;
        drive <= 1'b1;
        tx_data <= 8'h96;
        tx_valid <= 1'b1;
        host.set_cs(1'b0);
        host.recv(4, 1, sh);
        check({7'h00, lanes.enable[1]}, 8'h01);
        host.set_lane(3, 1'b0);
        host.wait_clk(8);
        #1;
        check({7'h00, lanes.enable[1]}, 8'h00);
        host.set_lane(3, 1'b1);
        host.wait_clk(8);
        host.recv(4, 1, sh);
        check(sh, 8'h96);
        check(8'(tx_loads - base), 8'h01);
        host.set_cs(1'b1);
        #1;
        check({4'h0, lanes.enable}, 8'h00);
        @(posedge clk);
        drive <= 1'b0;
        tx_valid <= 1'b0;
        $display("t_read done");
    endtask : t_read
    task automatic t_mread;
        logic [7:0] sh;
        int base;
        sh = 8'h00;
        base = tx_loads;
        @(posedge clk);
        mode <= flash_front_pkg::LANE_DUAL;
        drive <= 1'b1;
        tx_data <= 8'h6D;
        tx_valid <= 1'b1;
        host.set_cs(1'b0);
        host.recv(4, 2, sh);
        check({4'h0, lanes.enable}, 8'h03);
        check(sh, 8'h6D);
        host.set_cs(1'b1);
        wr_status(6'h10, 6'h10, 1'b0);
        @(posedge clk);
        mode <= flash_front_pkg::LANE_QUAD;
        tx_data <= 8'hB4;
        host.set_cs(1'b0);
        host.recv(2, 4, sh);
        check({4'h0, lanes.enable}, 8'h0F);
        check(sh, 8'hB4);
        check(8'(tx_loads - base), 8'h02);
        host.set_cs(1'b1);
        @(posedge clk);
        drive <= 1'b0;
        tx_valid <= 1'b0;
        mode <= flash_front_pkg::LANE_SINGLE;
        wr_status(6'h00, 6'h00, 1'b0);
        $display("t_mread done");
    endtask : t_mread
    // Reset pulses only with no internal write under way
    task automatic hw_case(input logic d, input logic s, input logic r, input logic by_pin,
            input logic exp);
        @(posedge clk);
        ded <= d;
        dis <= s;
        role <= r;
        host.set_cs(1'b0);
        if (by_pin) rpin_n <= 1'b0;
        else host.set_lane(3, 1'b0);
        host.wait_clk(8);
        rpin_n <= 1'b1;
        host.set_lane(3, 1'b1);
        host.wait_clk(8);
        host.send(8'h3C, 1);
        host.wait_clk(12);
        #1;
        check({7'h00, rx_valid}, {7'h00, exp});
        if (exp) rx_expect(8'h3C);
        host.set_cs(1'b1);
    endtask : hw_case
    task automatic t_hw;
        hw_case(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
        hw_case(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        hw_case(1'b1, 1'b0, 1'b1, 1'b0, 1'b1);
        hw_case(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        hw_case(1'b1, 1'b1, 1'b0, 1'b1, 1'b1);
        $display("t_hw done");
    endtask : t_hw
    ////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        rst <= 1'b1;
        mode <= flash_front_pkg::LANE_SINGLE;
        st_wd <= 6'h00;
        drive <= 1'b0;
        role <= 1'b0;
        ded <= 1'b0;
        dis <= 1'b0;
        st_wr <= 1'b0;
        tx_data <= 8'h00;
        tx_valid <= 1'b0;
        rx_ready <= 1'b0;
        ovf_clr <= 1'b0;
        rpin_n <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        host.wait_clk(4);
        #1;
        t_select();
        t_status();
        t_quad_fifo();
        t_read();
        t_mread();
        t_hw();
        report_and_stop();
    end
    // Whole run is near 2.6k cycles; 50k-cycle limit allows some nineteen times that
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
endmodule : serial_flash_pin_front_end_tb_top
